// ### rmwb_core.sv
`timescale 1ns/1ps
`default_nettype none
module rmwb_core
	import rmwb_pkg::*;
(
	input  wire logic       REF_CLK,      // system clock
	input  wire logic       ARST_N,       // async reset, active low
	input  wire logic       REQ_VALID,    // request strobe
	input  wire rmwb_req_t  REQ,          // request fields
	input  wire logic [7:0] PIN_IN,       // external pin levels
	output logic            BUSY,         // access in progress
	output logic            DONE,         // one-cycle completion pulse
	output logic [7:0]      RD_DATA,      // byte read (sampled at read step)
	output logic [7:0]      PIN_OUT,      // latch level onto pins
	output logic [7:0]      PIN_OE_N,     // low where pin drives
	output logic [7:0]      TIMER_COUNT,  // running counter
	output logic [7:0]      TIMER_RELOAD  // reload value
);
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_MODIFY, ST_WRITE} rmwb_state_t;

	rmwb_state_t state;
	rmwb_req_t   req;
	logic [7:0]  work;
	logic [7:0]  pin_meta;
	logic [7:0]  pin_sync;
	logic [7:0]  latch;
	logic [7:0]  dir;
	logic [7:0]  count;
	logic [7:0]  reload;
	logic        wr_now;
	logic [7:0]  port_rd;

	// per pin: outputs read back their latch, inputs read the synced pin
	// hazard: a bit op on the port copies input pin levels into the latch
	for (genvar g = 0; g < 8; g++)
	begin : g_port_rd
		assign port_rd[g] = dir[g] ? latch[g] : pin_sync[g];
	end

	// the timer address reads the counter, never the reload value
	function automatic logic [7:0] read_byte(input logic [1:0] a);
		case (a)
			ADDR_TIMER:     read_byte = count;
			ADDR_PORT_DATA: read_byte = port_rd;
			ADDR_PORT_DIR:  read_byte = DIR_READ_VALUE;
			default:        read_byte = RESET_BYTE;
		endcase
	endfunction

	function automatic logic [7:0] modify(input rmwb_req_t r, input logic [7:0] d);
		logic [7:0] m;
		m = RESET_BYTE;
		m[r.bit_sel] = 1'b1;
		case (r.op)
			RMWB_OP_SET:       modify = d | m;
			RMWB_OP_CLEAR:     modify = d & ~m;
			RMWB_OP_INVERT:    modify = d ^ m;
			RMWB_OP_STORE:     modify = r.carry ? (d | m) : (d & ~m);
			RMWB_OP_INV_STORE: modify = r.carry ? (d & ~m) : (d | m);
			default:           modify = d;
		endcase
	endfunction

	assign wr_now = (state == ST_WRITE);

	// pins are asynchronous to the clock
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			pin_meta <= RESET_BYTE;
			pin_sync <= RESET_BYTE;
		end
		else
		begin
			pin_meta <= PIN_IN;
			pin_sync <= pin_meta;
		end
	end

	// sequencer: plain write skips read, plain read skips write
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state   <= ST_IDLE;
			req     <= '0;
			work    <= RESET_BYTE;
			BUSY    <= 1'b0;
			DONE    <= 1'b0;
			RD_DATA <= RESET_BYTE;
		end
		else
		begin
			DONE <= 1'b0;
			case (state)
				ST_IDLE:
					if (REQ_VALID)
					begin
						req   <= REQ;
						work  <= REQ.wdata;
						BUSY  <= 1'b1;
						state <= (REQ.op == RMWB_OP_WRITE) ? ST_WRITE : ST_READ;
					end
				ST_READ:
				begin
					work    <= read_byte(req.addr);
					RD_DATA <= read_byte(req.addr);
					if (req.op == RMWB_OP_READ)
					begin
						state <= ST_IDLE;
						BUSY  <= 1'b0;
						DONE  <= 1'b1;
					end
					else
						state <= ST_MODIFY;
				end
				ST_MODIFY:
				begin
					work  <= modify(req, work);
					state <= ST_WRITE;
				end
				ST_WRITE:
				begin
					state <= ST_IDLE;
					BUSY  <= 1'b0;
					DONE  <= 1'b1;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// whole byte goes back, untouched bits included
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			latch <= RESET_BYTE;
			dir   <= RESET_BYTE;
		end
		else if (wr_now)
		begin
			if (req.addr == ADDR_PORT_DATA)
				latch <= work;
			if (req.addr == ADDR_PORT_DIR)
				dir <= work;
		end
	end

	// counter is never written by software; write lands in reload only
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			count  <= RESET_BYTE;
			reload <= RESET_RELOAD;
		end
		else
		begin
			if (count == COUNT_TOP)
				count <= reload;
			else
				count <= count + 8'h01;
			if (wr_now && req.addr == ADDR_TIMER)
				reload <= work;
		end
	end

	// outputs are registered copies, so each lags its source by one cycle

	// pins show the latch, whatever the direction bit says
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			PIN_OUT <= RESET_BYTE;
		else
			PIN_OUT <= latch;
	end

	// all pins start as inputs, so nothing is driven out of reset
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			PIN_OE_N <= OE_RESET;
		else
			PIN_OE_N <= ~dir;
	end

	// the counter copy lets the far side see it keep running
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			TIMER_COUNT <= RESET_BYTE;
		else
			TIMER_COUNT <= count;
	end

	// reload copy shows what a timer write really left behind
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			TIMER_RELOAD <= RESET_RELOAD;
		else
			TIMER_RELOAD <= reload;
	end
endmodule
`default_nettype wire

// ### rmwb_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rmwb_core_chk
	import rmwb_pkg::*;
(
	input wire logic       REF_CLK,
	input wire logic       ARST_N,
	input wire logic       REQ_VALID,
	input wire rmwb_req_t  REQ,
	input wire logic       BUSY,
	input wire logic       DONE,
	input wire logic [7:0] PIN_OUT,
	input wire logic [7:0] PIN_OE_N,
	input wire logic [7:0] TIMER_COUNT,
	input wire logic [7:0] TIMER_RELOAD
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	wire t = REQ_VALID && !BUSY;
	wire b = REQ.op > RMWB_OP_WRITE;
	AST_TAKE: assert property (t |=> BUSY) else $error("busy missing");
	AST_BIT: assert property (t && b |=> !DONE [*3] ##1 DONE) else $error("bit op");
	AST_RW: assert property (t && !b |=> !DONE ##1 DONE) else $error("byte op");
	AST_PULSE: assert property (DONE |=> !DONE) else $error("done width");
	// output lags the counter, so skip the first edges after reset
	AST_CNT: assert property ($past(ARST_N, 3) && TIMER_COUNT != COUNT_TOP
		|=> TIMER_COUNT == $past(TIMER_COUNT) + 8'h1) else $error("count");
	AST_RLD: assert property ($changed(TIMER_RELOAD) |-> $past(DONE)) else $error("rld");
	AST_LAT: assert property ($changed(PIN_OUT) |-> $past(DONE)) else $error("latch");
	AST_DIR: assert property ($changed(PIN_OE_N) |-> $past(DONE)) else $error("dir");
	cover property (t && REQ.op == RMWB_OP_SET);
	cover property (t && b && REQ.addr == ADDR_TIMER);
	cover property (t && REQ.op == RMWB_OP_WRITE);
endmodule
bind rmwb_core rmwb_core_chk u_chk (.REF_CLK, .ARST_N, .REQ_VALID, .REQ, .BUSY, .DONE,
	.PIN_OUT, .PIN_OE_N, .TIMER_COUNT, .TIMER_RELOAD);
`default_nettype wire

// ### rmwb_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module rmwb_core_test
	import rmwb_pkg::*;
;
	logic clk = 0, rst_n = 0, vld = 0, busy, done, c;
	rmwb_req_t r = '0;
	logic [7:0] ext = 0, pin, rd, po, oe, cnt, rl, dr, lt, x, sh;
	logic [2:0] k;
	rmwb_op_t o;
	int failures = 0, checked = 0, seed = 32'h1fb6, cyc = 0;
	initial forever #25 clk = ~clk;
	rmwb_core dut (.REF_CLK(clk), .ARST_N(rst_n), .REQ_VALID(vld), .REQ(r), .PIN_IN(pin),
		.BUSY(busy), .DONE(done), .RD_DATA(rd), .PIN_OUT(po), .PIN_OE_N(oe),
		.TIMER_COUNT(cnt), .TIMER_RELOAD(rl));
	rmwb_pins pins (.PIN_OUT(po), .PIN_OE_N(oe), .EXT(ext), .PIN_IN(pin));
	task chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	function logic [7:0] mdf(rmwb_op_t p, logic [2:0] i, logic q, logic [7:0] v);
		case (p)
			RMWB_OP_SET: v[i] = 1'b1;
			RMWB_OP_CLEAR: v[i] = 1'b0;
			RMWB_OP_INVERT: v[i] = ~v[i];
			RMWB_OP_STORE: v[i] = q;
			default: v[i] = ~q;
		endcase
		return v;
	endfunction
	task acc(rmwb_op_t p, logic [1:0] a, logic [2:0] i, logic q, logic [7:0] w);
		int n;
		r = '{p, a, i, q, w};
		vld = 1;
		@(posedge clk) #1 vld = 0;
		for (n = 0; n < 9 && done !== 1'b1; n++) @(posedge clk) #1;
		chk("done", {7'h0, done}, 8'h1);
		@(posedge clk) #1;
	endtask
	task final_report;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) if (++cyc > 3000) begin failures++; final_report; end
	initial
	begin
		repeat (5) @(posedge clk);
		#1 rst_n = 1;
		ext = 8'h40;
		acc(RMWB_OP_WRITE, ADDR_PORT_DIR, 0, 0, 8'h3f);
		acc(RMWB_OP_WRITE, ADDR_PORT_DATA, 0, 0, 8'h80);
		acc(RMWB_OP_SET, ADDR_PORT_DATA, 0, 0, 0);
		chk("rd", rd, 8'h40);
		chk("out", po, 8'h41);
		chk("oe", oe, 8'hc0);
		repeat (24)
		begin
			{dr, lt, ext} = {$random(seed), $random(seed)};
			{k, c} = 4'($random(seed));
			o = rmwb_op_t'(3'd2 + 3'($unsigned($random(seed)) % 5));
			acc(RMWB_OP_WRITE, ADDR_PORT_DIR, 0, 0, dr);
			acc(RMWB_OP_WRITE, ADDR_PORT_DATA, 0, 0, lt);
			acc(o, ADDR_PORT_DATA, k, c, 0);
			x = (dr & lt) | (~dr & ext);
			chk("rd", rd, x);
			chk("out", po, mdf(o, k, c, x));
		end
		$display("port test end");
		acc(RMWB_OP_WRITE, ADDR_TIMER, 0, 0, 8'h5a);
		chk("rld", rl, 8'h5a);
		acc(RMWB_OP_CLEAR, ADDR_TIMER, 3, 0, 0);
		chk("rld", rl, mdf(RMWB_OP_CLEAR, 3, 0, rd));
		acc(RMWB_OP_READ, ADDR_TIMER, 0, 0, 0);
		chk("cnt", cnt, (rd == COUNT_TOP) ? rl : rd + 8'h01);
		acc(RMWB_OP_READ, 2'h3, 0, 0, 0);
		chk("unmapped", rd, RESET_BYTE);
		acc(RMWB_OP_WRITE, ADDR_PORT_DIR, 0, 0, 8'h3f);
		sh = 8'h80;
		ext = 8'h40;
		acc(RMWB_OP_WRITE, ADDR_PORT_DATA, 0, 0, sh);
		sh = mdf(RMWB_OP_SET, 0, 0, sh);
		acc(RMWB_OP_WRITE, ADDR_PORT_DATA, 0, 0, sh);
		chk("shadow", po, 8'h81);
		acc(RMWB_OP_READ, ADDR_PORT_DIR, 0, 0, 0);
		chk("dir", rd, DIR_READ_VALUE);
		$display("timer test end");
		final_report;
	end
endmodule
`default_nettype wire

// ### rmwb_pins.sv
`timescale 1ns/1ps
`default_nettype none
module rmwb_pins (
	input  wire logic [7:0] PIN_OUT,  // latch level
	input  wire logic [7:0] PIN_OE_N, // low where driven
	input  wire logic [7:0] EXT,      // outside level
	output logic [7:0]      PIN_IN    // resolved pin
);
	assign PIN_IN = (~PIN_OE_N & PIN_OUT) | (PIN_OE_N & EXT);
endmodule
`default_nettype wire

// ### rmwb_pkg.sv
`default_nettype none
package rmwb_pkg;
	localparam logic [1:0] ADDR_TIMER     = 2'h0;
	localparam logic [1:0] ADDR_PORT_DATA = 2'h1;
	localparam logic [1:0] ADDR_PORT_DIR  = 2'h2;
	localparam logic [7:0] DIR_READ_VALUE = 8'hff;
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [7:0] RESET_RELOAD   = 8'h00;
	localparam logic [7:0] COUNT_TOP      = 8'hff;
	localparam logic [7:0] OE_RESET       = 8'hff;

	typedef enum logic [2:0] {
		RMWB_OP_READ,
		RMWB_OP_WRITE,
		RMWB_OP_SET,
		RMWB_OP_CLEAR,
		RMWB_OP_INVERT,
		RMWB_OP_STORE,
		RMWB_OP_INV_STORE
	} rmwb_op_t;

	typedef struct packed {
		rmwb_op_t   op;
		logic [1:0] addr;
		logic [2:0] bit_sel;
		logic       carry;
		logic [7:0] wdata;
	} rmwb_req_t;
endpackage
`default_nettype wire
